// [msr_host_if.sv]
`timescale 1ns/100ps
interface msr_host_if;
    msr_pkg::msr_addr_t addr;
    msr_pkg::msr_word_t wdata;
    msr_pkg::msr_word_t rdata;
    msr_pkg::msr_word_t last_val;
    logic rd_stb;
    logic wr_stb;
    logic last_stb;

    modport link (output addr, wdata, rd_stb, wr_stb, last_stb, last_val, input rdata);
    modport bank (input addr, wdata, rd_stb, wr_stb, last_stb, last_val, output rdata);
endinterface

// [msr_host_model.sv]
`timescale 1ns/100ps
module msr_host_model
    import msr_pkg::*;
(
    // clock
    input wire logic sys_clk_i,
    // serial pins
    output logic sclk_o,
    output logic cs_b_o,
    output logic sdi_o,
    input wire logic sdo_i,
    input wire logic sdo_oe_i
);
    // ====================
    // frame driver
    initial
    begin
        sclk_o = 1'b1;
        cs_b_o = 1'b1;
        sdi_o = 1'b0;
    end

    // half is in sys_clk cycles; the device needs at least two for reads
    task automatic xfer(input logic rd, input msr_addr_t a, input msr_word_t d,
                        input int half, output msr_word_t q);
        logic [23:0] frame;
        frame = {rd, a, d};
        q = 16'h0000;
        @(negedge sys_clk_i);
        cs_b_o = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            sclk_o = 1'b0;
            sdi_o = frame[i];
            repeat (half) @(negedge sys_clk_i);
            sclk_o = 1'b1;
            if (i < 16)
                q[i] = sdo_oe_i ? sdo_i : 1'bx;
            repeat (half) @(negedge sys_clk_i);
        end
        cs_b_o = 1'b1;
        // released line shows the inverse, never a stale bit
        sdi_o = ~sdi_o;
        repeat (4) @(negedge sys_clk_i);
    endtask
endmodule

// [msr_pkg.sv]
package msr_pkg;
    typedef logic [6:0] msr_addr_t;
    typedef logic [15:0] msr_word_t;
endpackage

// [msr_regs.svh]
`ifndef MSR_REGS_SVH
`define MSR_REGS_SVH

// ==========================================================
// register addresses
`define MSR_ADDR_RESET_KEY 7'h00
`define MSR_ADDR_EVENT_FLAGS 7'h01
`define MSR_ADDR_FEATURE_EN 7'h02
`define MSR_ADDR_UV_THRESHOLD 7'h03
`define MSR_ADDR_LOW_POWER 7'h04
`define MSR_ADDR_LAST_XFER 7'h06

// ==========================================================
// reset values and keys
`define MSR_RST_ZERO 16'h0000
`define MSR_RST_FEATURE_EN 16'h000C
`define MSR_RST_UV_THRESHOLD 16'h1D6A
`define MSR_SOFT_RESET_KEY 16'h789A
`define MSR_LOW_POWER_KEY 16'hA987

// ==========================================================
// field positions
`define MSR_EV_CAL_LO 14
`define MSR_EV_ADJ_LO 12
`define MSR_EV_LINE 7
`define MSR_EV_REACT 6
`define MSR_EV_ACT 5
`define MSR_EV_UV 1
`define MSR_FE_UV_EN 5
`define MSR_FE_UV_WO 4
`define MSR_FE_REACT_EN 3
`define MSR_FE_ACT_EN 2

// ==========================================================
// serial frame, timing and power scaling
`define MSR_FRAME_BITS 24
`define MSR_HDR_BITS 8
`define MSR_CLK_PERIOD_NS 5
`define MSR_TIMEOUT_MS 6
`define MSR_TIMEOUT_CYCLES (`MSR_TIMEOUT_MS * 1000000 / `MSR_CLK_PERIOD_NS)
`define MSR_SCALE_DIV 100000
`define MSR_SCALE_SHIFT 42

`endif

// [msr_sag_detect.sv]
`timescale 1ns/100ps
module msr_sag_detect
    import msr_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // line samples
    input wire logic zero_cross_i,
    input wire msr_word_t voltage_i,
    input wire msr_word_t threshold_i,
    // result
    output logic sag_pulse_o
);
    logic armed, all_below, below;

    assign below = voltage_i < threshold_i;

    // the first window opens at a crossing, so no sag before two crossings
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
        begin
            armed <= 1'b0;
            all_below <= 1'b0;
            sag_pulse_o <= 1'b0;
        end
        else if (zero_cross_i)
        begin
            sag_pulse_o <= armed & all_below & below;
            armed <= 1'b1;
            all_below <= below;
        end
        else
        begin
            sag_pulse_o <= 1'b0;
            all_below <= all_below & below;
        end

    a_sag_at_cross: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        sag_pulse_o |-> $past(zero_cross_i) && $past(voltage_i) < $past(threshold_i))
        else $error("sag reported away from a crossing or above threshold");
endmodule

// [msr_spi_link.sv]
`timescale 1ns/100ps
`include "msr_regs.svh"
module msr_spi_link
    import msr_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = `MSR_TIMEOUT_CYCLES
)
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // serial pins
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    // register side
    msr_host_if.link host
);
    localparam logic [4:0] FRAME = 5'(`MSR_FRAME_BITS);
    localparam logic [4:0] HDR = 5'(`MSR_HDR_BITS);

    logic sclk_q, cs_q, rw_q, rd_req, hdr_pulse, timed_out;
    logic [4:0] bit_cnt;
    logic [23:0] shift_in;
    logic [15:0] shift_out, rd_word;
    logic [20:0] idle_cnt;
    logic rise, fall, active, frame_end;

    assign rise = sclk_i & ~sclk_q;
    assign fall = ~sclk_i & sclk_q;
    assign active = ~cs_b_i;
    assign frame_end = cs_b_i & ~cs_q;
    assign host.rd_stb = rd_req;
    assign sdo_o = shift_out[15];
    // rw_q is stale until the cycle after the header completes
    assign sdo_oe_o = active & rw_q & (bit_cnt >= HDR) & ~hdr_pulse;

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
        begin
            sclk_q <= 1'b1;
            cs_q <= 1'b1;
        end
        else
        begin
            sclk_q <= sclk_i;
            cs_q <= cs_b_i;
        end

    // bits past the 24th are counted once but never shifted
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
        begin
            bit_cnt <= 5'h00;
            shift_in <= 24'h000000;
            hdr_pulse <= 1'b0;
        end
        else
        begin
            hdr_pulse <= active & rise & (bit_cnt == HDR - 5'h01);
            if (!active)
                bit_cnt <= 5'h00;
            else if (rise && bit_cnt <= FRAME)
            begin
                if (bit_cnt < FRAME)
                    shift_in <= {shift_in[22:0], sdi_i};
                bit_cnt <= bit_cnt + 5'h01;
            end
        end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
        begin
            host.addr <= 7'h00;
            rw_q <= 1'b0;
            rd_req <= 1'b0;
        end
        else
        begin
            rd_req <= hdr_pulse & shift_in[7];
            if (hdr_pulse)
            begin
                host.addr <= shift_in[6:0];
                rw_q <= shift_in[7];
            end
        end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
        begin
            shift_out <= 16'h0000;
            rd_word <= 16'h0000;
        end
        else if (rd_req)
        begin
            shift_out <= host.rdata;
            rd_word <= host.rdata;
        end
        else if (active && fall && bit_cnt > HDR)
            shift_out <= {shift_out[14:0], 1'b0};

    // a stalled clock aborts writes; reads of 24 or more bits still count
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
        begin
            idle_cnt <= 21'h000000;
            timed_out <= 1'b0;
        end
        else
        begin
            if (!active || rise || fall)
                idle_cnt <= 21'h000000;
            else if (!timed_out)
                idle_cnt <= idle_cnt + 21'h000001;
            timed_out <= active & (timed_out | (idle_cnt == 21'(TIMEOUT_CYCLES - 1)));
        end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
        begin
            host.wr_stb <= 1'b0;
            host.last_stb <= 1'b0;
            host.wdata <= 16'h0000;
            host.last_val <= 16'h0000;
        end
        else
        begin
            host.wr_stb <= frame_end & ~rw_q & (bit_cnt == FRAME) & ~timed_out;
            host.last_stb <= frame_end & (rw_q ? (bit_cnt >= FRAME)
                             : ((bit_cnt == FRAME) & ~timed_out));
            if (frame_end)
            begin
                host.wdata <= shift_in[15:0];
                host.last_val <= rw_q ? rd_word : shift_in[15:0];
            end
        end

    a_write_frame_len: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        host.wr_stb |-> ($past(bit_cnt) == FRAME) && !$past(timed_out))
        else $error("write accepted without a clean 24 bit frame");
endmodule

// [msr_status_bank.sv]
`timescale 1ns/100ps
`include "msr_regs.svh"
module msr_status_bank
    import msr_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = `MSR_TIMEOUT_CYCLES
)
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // serial host port
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    // checksum checker levels
    input wire logic metering_checksum_error_i,
    input wire logic measurement_checksum_error_i,
    // metering core events, one cycle pulses
    input wire logic metering_line_changed_i,
    input wire logic reactive_direction_changed_i,
    input wire logic active_direction_changed_i,
    // voltage channel
    input wire logic zero_cross_i,
    input wire msr_word_t voltage_i,
    // power path, small mode scale
    input wire logic signed [31:0] active_power_raw_i,
    input wire logic signed [31:0] reactive_power_raw_i,
    input wire msr_word_t current_gain_i,
    input wire msr_word_t voltage_gain_i,
    // outputs
    output logic irq_o,
    output logic fatal_warning_output_o,
    output logic soft_reset_o,
    output logic low_power_mode_o,
    output logic signed [15:0] active_power_o,
    output logic signed [15:0] reactive_power_o
);
    // ==========================================================
    // address decode
    function automatic logic addr_is(input msr_addr_t a, input msr_addr_t ref_addr);
        addr_is = (a == ref_addr);
    endfunction

    msr_host_if host ();

    msr_word_t feature_enable_bits;
    msr_word_t undervoltage_threshold;
    msr_word_t low_power_scale_key;
    msr_word_t last_transfer_value;
    logic [1:0] metering_checksum_bits;
    logic [1:0] measurement_checksum_bits;
    logic metering_line_changed;
    logic reactive_direction_changed;
    logic active_direction_changed;
    logic undervoltage_flag;
    logic next_line, next_react, next_act, next_uv;
    logic sag_pulse, flags_read, soft_reset;
    logic wr_key, wr_fe, wr_uv, wr_lp;
    msr_word_t system_event_flags;

    // ==========================================================
    // serial port and sag detector
    msr_spi_link #(
        .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
    ) u_link (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .sclk_i(sclk_i),
        .cs_b_i(cs_b_i),
        .sdi_i(sdi_i),
        .sdo_o(sdo_o),
        .sdo_oe_o(sdo_oe_o),
        .host(host.link)
    );

    msr_sag_detect u_sag (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .zero_cross_i(zero_cross_i),
        .voltage_i(voltage_i),
        .threshold_i(undervoltage_threshold),
        .sag_pulse_o(sag_pulse)
    );

    // ==========================================================
    // write decode and flags read strobe; unknown addresses match nothing and are dropped
    assign wr_key = host.wr_stb & addr_is(host.addr, `MSR_ADDR_RESET_KEY);
    assign wr_fe = host.wr_stb & addr_is(host.addr, `MSR_ADDR_FEATURE_EN);
    assign wr_uv = host.wr_stb & addr_is(host.addr, `MSR_ADDR_UV_THRESHOLD);
    assign wr_lp = host.wr_stb & addr_is(host.addr, `MSR_ADDR_LOW_POWER);
    assign flags_read = host.rd_stb & addr_is(host.addr, `MSR_ADDR_EVENT_FLAGS);

    // ==========================================================
    // software reset: a one cycle pulse that also restores the writable registers and the sticky events, not the last transfer value
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
            soft_reset <= 1'b0;
        else
            soft_reset <= wr_key & (host.wdata == `MSR_SOFT_RESET_KEY);

    assign soft_reset_o = soft_reset;

    // ==========================================================
    // writable configuration
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
            feature_enable_bits <= `MSR_RST_FEATURE_EN;
        else if (soft_reset)
            feature_enable_bits <= `MSR_RST_FEATURE_EN;
        else if (wr_fe)
            feature_enable_bits <= host.wdata & 16'h003C;

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
            undervoltage_threshold <= `MSR_RST_UV_THRESHOLD;
        else if (soft_reset)
            undervoltage_threshold <= `MSR_RST_UV_THRESHOLD;
        else if (wr_uv)
            undervoltage_threshold <= host.wdata;

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
            low_power_scale_key <= `MSR_RST_ZERO;
        else if (soft_reset)
            low_power_scale_key <= `MSR_RST_ZERO;
        else if (wr_lp)
            low_power_scale_key <= host.wdata;

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
            low_power_mode_o <= 1'b0;
        else
            low_power_mode_o <= (low_power_scale_key == `MSR_LOW_POWER_KEY);

    // ==========================================================
    // last word moved over the host port
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
            last_transfer_value <= `MSR_RST_ZERO;
        else if (host.last_stb)
            last_transfer_value <= host.last_val;

    // ==========================================================
    // checksum status: levels follow the checkers, not cleared by reads
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
        begin
            metering_checksum_bits <= 2'h0;
            measurement_checksum_bits <= 2'h0;
        end
        else
        begin
            metering_checksum_bits <= {2{metering_checksum_error_i}};
            measurement_checksum_bits <= {2{measurement_checksum_error_i}};
        end

    // ==========================================================
    // sticky events; a new event in the read cycle survives the clear
    always_comb
    begin
        next_line = metering_line_changed & ~flags_read;
        next_react = reactive_direction_changed & ~flags_read;
        next_act = active_direction_changed & ~flags_read;
        next_uv = undervoltage_flag & ~flags_read;
        if (metering_line_changed_i)
            next_line = 1'b1;
        if (reactive_direction_changed_i && feature_enable_bits[`MSR_FE_REACT_EN])
            next_react = 1'b1;
        if (active_direction_changed_i && feature_enable_bits[`MSR_FE_ACT_EN])
            next_act = 1'b1;
        if (sag_pulse && feature_enable_bits[`MSR_FE_UV_EN])
            next_uv = 1'b1;
        if (soft_reset)
        begin
            next_line = 1'b0;
            next_react = 1'b0;
            next_act = 1'b0;
            next_uv = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
        begin
            metering_line_changed <= 1'b0;
            reactive_direction_changed <= 1'b0;
            active_direction_changed <= 1'b0;
            undervoltage_flag <= 1'b0;
        end
        else
        begin
            metering_line_changed <= next_line;
            reactive_direction_changed <= next_react;
            active_direction_changed <= next_act;
            undervoltage_flag <= next_uv;
        end

    always_comb
    begin
        system_event_flags = 16'h0000; // reserved bits read zero
        system_event_flags[`MSR_EV_CAL_LO +: 2] = metering_checksum_bits;
        system_event_flags[`MSR_EV_ADJ_LO +: 2] = measurement_checksum_bits;
        system_event_flags[`MSR_EV_LINE] = metering_line_changed;
        system_event_flags[`MSR_EV_REACT] = reactive_direction_changed;
        system_event_flags[`MSR_EV_ACT] = active_direction_changed;
        system_event_flags[`MSR_EV_UV] = undervoltage_flag;
    end

    // ==========================================================
    // interrupt and warning pins
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
        if (!rst_b_i)
        begin
            irq_o <= 1'b0;
            fatal_warning_output_o <= 1'b0;
        end
        else
        begin
            irq_o <= next_line | next_react | next_act | next_uv
                     | metering_checksum_error_i | measurement_checksum_error_i;
            fatal_warning_output_o <= metering_checksum_error_i
                | (next_uv & feature_enable_bits[`MSR_FE_UV_WO]);
        end

    // ==========================================================
    // read mux
    always_comb
    begin
        host.rdata = 16'h0000;
        if (addr_is(host.addr, `MSR_ADDR_EVENT_FLAGS))
            host.rdata = system_event_flags;
        else if (addr_is(host.addr, `MSR_ADDR_FEATURE_EN))
            host.rdata = feature_enable_bits;
        else if (addr_is(host.addr, `MSR_ADDR_UV_THRESHOLD))
            host.rdata = undervoltage_threshold;
        else if (addr_is(host.addr, `MSR_ADDR_LOW_POWER))
            host.rdata = low_power_scale_key;
        else if (addr_is(host.addr, `MSR_ADDR_LAST_XFER))
            host.rdata = last_transfer_value;
    end

    // ==========================================================
    // power reporting; the core works on the small mode scale, so normal
    // mode converts with the gains (divider is slow but off the bus path)
    logic signed [31:0] raw_power [2];
    logic signed [15:0] rep_power [2];
    assign raw_power[0] = active_power_raw_i;
    assign raw_power[1] = reactive_power_raw_i;

    generate
        for (genvar ch = 0; ch < 2; ch++)
        begin : g_power
            logic signed [64:0] prod;
            logic signed [64:0] scaled;
            assign prod = 65'(raw_power[ch]) * 65'($signed({1'b0, current_gain_i}))
                          * 65'($signed({1'b0, voltage_gain_i}));
            assign scaled = (prod >>> `MSR_SCALE_SHIFT) / 65'sd100000;
            always_ff @(posedge sys_clk_i or negedge rst_b_i)
                if (!rst_b_i)
                    rep_power[ch] <= 16'sh0000;
                else if (low_power_mode_o)
                    rep_power[ch] <= raw_power[ch][15:0];
                else
                    rep_power[ch] <= scaled[15:0];
        end
    endgenerate

    assign active_power_o = rep_power[0];
    assign reactive_power_o = rep_power[1];

    // ==========================================================
    // checks
    a_reset_key_only: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        host.wr_stb && host.wdata != `MSR_SOFT_RESET_KEY |=> !soft_reset_o)
        else $error("software reset from a wrong key");

    a_cal_err_warn: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        metering_checksum_error_i |=> system_event_flags[15:14] == 2'b11
        && fatal_warning_output_o && irq_o)
        else $error("checksum one error not shown");

    a_adj_err_bits: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $past(measurement_checksum_error_i) == (system_event_flags[13:12] == 2'b11))
        else $error("checksum two bits wrong");

    a_line_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        metering_line_changed_i && !soft_reset |=> system_event_flags[7] [*2])
        else $error("line change lost");

    a_react_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $rose(reactive_direction_changed) |-> $past(feature_enable_bits[3]))
        else $error("reactive flag set while disabled");

    a_act_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $rose(active_direction_changed) |-> $past(feature_enable_bits[2]))
        else $error("active flag set while disabled");

    a_sag_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $rose(undervoltage_flag) |-> $past(sag_pulse) && $past(feature_enable_bits[5]))
        else $error("sag flag without enabled sag");

    a_irq_tracks: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        irq_o == ((|system_event_flags[7:0]) | $past(metering_checksum_error_i)
                  | $past(measurement_checksum_error_i)))
        else $error("interrupt out of step with events");

    a_read_clears: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        flags_read && !metering_line_changed_i |=> !system_event_flags[7])
        else $error("status read did not clear");

    a_low_power_key: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        wr_lp && !soft_reset ##1 1 |=> low_power_mode_o == ($past(host.wdata, 2) == 16'hA987))
        else $error("small mode does not follow key");
endmodule

// [testbench.sv]
`timescale 1ns/100ps
module testbench
    import msr_pkg::*;
;
    logic sys_clk_i, rst_b_i, sclk, cs_b, sdi, sdo, sdo_oe;
    logic cal_err, adj_err, line_chg, react_chg, act_chg, zc;
    logic irq, warn, soft_rst, low_pwr;
    logic signed [31:0] act_raw, react_raw;
    logic signed [15:0] act_pwr, react_pwr;
    msr_word_t volt, i_gain, u_gain;
    int miscompares, checks, resets_seen;

    msr_status_bank #(.TIMEOUT_CYCLES(50)) i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .sclk_i(sclk), .cs_b_i(cs_b), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
        .metering_checksum_error_i(cal_err), .measurement_checksum_error_i(adj_err),
        .metering_line_changed_i(line_chg), .reactive_direction_changed_i(react_chg),
        .active_direction_changed_i(act_chg), .zero_cross_i(zc), .voltage_i(volt),
        .active_power_raw_i(act_raw), .reactive_power_raw_i(react_raw),
        .current_gain_i(i_gain), .voltage_gain_i(u_gain), .irq_o(irq),
        .fatal_warning_output_o(warn), .soft_reset_o(soft_rst), .low_power_mode_o(low_pwr),
        .active_power_o(act_pwr), .reactive_power_o(react_pwr));
    msr_host_model i_host (.sys_clk_i(sys_clk_i), .sclk_o(sclk), .cs_b_o(cs_b),
        .sdi_o(sdi), .sdo_i(sdo), .sdo_oe_i(sdo_oe));

    // ====================
    // clock and helpers
    initial
    begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i)
        if (soft_rst === 1'b1)
            resets_seen++;

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input msr_addr_t a, input msr_word_t d);
        msr_word_t v;
        i_host.xfer(1'b0, a, d, 7, v);
    endtask
    task automatic rd_chk(input string n, input msr_addr_t a, input msr_word_t e);
        msr_word_t v;
        i_host.xfer(1'b1, a, 16'h0000, 4, v);
        chk(n, e, v);
    endtask
    task automatic sag_window();
        volt = 16'h0100;
        repeat (2) @(negedge sys_clk_i) zc = ~zc;
        repeat (10) @(negedge sys_clk_i);
        repeat (2) @(negedge sys_clk_i) zc = ~zc;
        repeat (4) @(negedge sys_clk_i);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ====================
    // scenarios
    task automatic t_defaults();
        rd_chk("feature", 7'h02, 16'h000C);
        rd_chk("threshold", 7'h03, 16'h1D6A);
        rd_chk("key", 7'h04, 16'h0000);
        rd_chk("unmapped", 7'h05, 16'h0000);
        wr(7'h03, 16'h1234);
        rd_chk("threshold", 7'h03, 16'h1234);
        rd_chk("last", 7'h06, 16'h1234);
        wr(7'h05, 16'hFFFF);
        wr(7'h01, 16'hFFFF);
        rd_chk("unmapped", 7'h05, 16'h0000);
        rd_chk("flags", 7'h01, 16'h0000);
        wr(7'h03, 16'h1D6A);
    endtask
    task automatic t_events(input msr_word_t e);
        @(negedge sys_clk_i) {line_chg, react_chg, act_chg} = 3'h7;
        @(negedge sys_clk_i) {line_chg, react_chg, act_chg} = 3'h0;
        @(negedge sys_clk_i) chk("irq", 16'h0001, irq);
        rd_chk("flags", 7'h01, e);
        rd_chk("flags", 7'h01, 16'h0000);
        chk("irq", 16'h0000, irq);
    endtask
    task automatic t_checksum();
        cal_err = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        chk("warn", 16'h0001, warn);
        rd_chk("flags", 7'h01, 16'hC000);
        {cal_err, adj_err} = 2'b01;
        repeat (3) @(negedge sys_clk_i);
        chk("warn", 16'h0000, warn);
        rd_chk("flags", 7'h01, 16'h3000);
        adj_err = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        chk("irq", 16'h0000, irq);
    endtask
    task automatic t_sag();
        sag_window();
        chk("warn", 16'h0001, warn);
        chk("irq", 16'h0001, irq);
        rd_chk("flags", 7'h01, 16'h0002);
        chk("warn", 16'h0000, warn);
        wr(7'h02, 16'h000C);
        sag_window();
        rd_chk("flags", 7'h01, 16'h0000);
        volt = 16'hFFFF;
    endtask
    task automatic t_power();
        wr(7'h04, 16'hA987);
        chk("mode", 16'h0001, low_pwr);
        chk("active", 16'h2345, act_pwr);
        chk("reactive", 16'h8001, react_pwr);
        rd_chk("key", 7'h04, 16'hA987);
        rd_chk("last", 7'h06, 16'hA987);
        wr(7'h04, 16'hA986);
        chk("mode", 16'h0000, low_pwr);
        chk("active", 16'h0000, act_pwr);
        @(negedge sys_clk_i) {act_raw, i_gain, u_gain} = 64'h7FFF_FFFF_FFFF_FFFF;
        repeat (2) @(negedge sys_clk_i);
        chk("active", 16'h0014, act_pwr);
        chk("reactive", 16'h0000, react_pwr);
    endtask
    task automatic t_soft_reset();
        wr(7'h00, 16'h1234);
        chk("resets", 16'h0000, resets_seen[15:0]);
        rd_chk("feature", 7'h02, 16'h0000);
        wr(7'h00, 16'h789A);
        chk("resets", 16'h0001, resets_seen[15:0]);
        rd_chk("feature", 7'h02, 16'h000C);
    endtask

    // ====================
    // main sequence and watchdog
    initial
    begin
        {rst_b_i, cal_err, adj_err, line_chg, react_chg, act_chg, zc} = 7'h00;
        volt = 16'hFFFF;
        {i_gain, u_gain} = 32'h0001_0001;
        act_raw = 32'h0001_2345;
        react_raw = -32'sh7FFF;
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i) rst_b_i = 1'b1;
        t_defaults();
        t_events(16'h00E0);
        wr(7'h02, 16'h0030);
        t_events(16'h0080);
        t_checksum();
        t_sag();
        t_power();
        wr(7'h02, 16'h0000);
        t_soft_reset();
        tally_and_finish();
    end
    initial
    begin
        repeat (100000) @(posedge sys_clk_i);
        miscompares++;
        $display("mismatch watchdog expected done seen hang");
        tally_and_finish();
    end
endmodule
